// ---- dv/fifo_dev_model.sv ----
// Behavioural bank of cascaded asynchronous FIFO devices
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model
	import fifo_host_pkg::*;
#(
	parameter int DEPTH = 4
)(
	input  wire logic [N_DEV-1:0]  i_write_n,
	input  wire logic [N_DEV-1:0]  i_read_n,
	input  wire logic              i_clear_n,
	input  wire logic              i_replay_n,
	input  wire logic [N_DEV-1:0]  i_token_in_n,
	input  wire logic [DATA_W-1:0] i_data,
	output logic      [DATA_W-1:0] o_data,
	output logic      [N_DEV-1:0]  o_empty_n,
	output logic      [N_DEV-1:0]  o_full_n,
	output logic                   o_half_n,
	output logic      [N_DEV-1:0]  o_token_out_n
);
	logic [DATA_W-1:0] mem [N_DEV][DEPTH];
	logic [DATA_W-1:0] q [N_DEV];
	logic [DATA_W-1:0] last = '0;
	logic [N_DEV-1:0]  rd_ok = '0;
	int                wp [N_DEV];
	int                rp [N_DEV];
	int                cnt [N_DEV];
	logic              depth = 1'b0;
	// Mode is taken from the token wiring when clear ends
	always @(posedge i_clear_n) begin
		depth = (i_token_in_n[0] === 1'b1);
		for (int i = 0; i < N_DEV; i++) begin
			wp[i] = 0;
			rp[i] = 0;
			cnt[i] = 0;
		end
	end
	// Replay rewinds reading; ignored when cascaded in depth
	always @(negedge i_replay_n) begin
		for (int i = 0; i < N_DEV; i++) begin
			if (!depth) begin
				cnt[i] = cnt[i] + rp[i];
				rp[i] = 0;
			end
		end
	end
	for (genvar g = 0; g < N_DEV; g++) begin : g_dev
		logic tok = 1'b1;
		assign o_token_out_n[g] = tok;
		assign o_empty_n[g] = (cnt[g] != 0);
		assign o_full_n[g] = (cnt[g] != DEPTH);
		// Rising write edge stores; a full device ignores it
		always @(posedge i_write_n[g]) begin
			if (cnt[g] < DEPTH) begin
				mem[g][wp[g]] = i_data;
				if (depth && wp[g] == DEPTH - 1) begin
					tok <= 1'b0;
					tok <= #150 1'b1;
				end
				wp[g] = (wp[g] + 1) % DEPTH;
				cnt[g]++;
			end
		end
		// Empty device ignores the read strobe
		always @(negedge i_read_n[g]) begin
			if (cnt[g] > 0) begin
				q[g] = mem[g][rp[g]];
				rd_ok[g] = 1'b1;
			end
		end
		always @(posedge i_read_n[g]) begin
			if (rd_ok[g]) begin
				rd_ok[g] = 1'b0;
				last = q[g];
				if (depth && rp[g] == DEPTH - 1) begin
					tok <= 1'b0;
					tok <= #150 1'b1;
				end
				rp[g] = (rp[g] + 1) % DEPTH;
				cnt[g]--;
			end
		end
	end
	assign o_half_n = depth | (cnt[0] <= DEPTH / 2);
	// Floating bus shows the inverse of the last word
	always @* begin
		o_data = ~last;
		for (int i = 0; i < N_DEV; i++) begin
			if (!i_read_n[i] && rd_ok[i]) begin
				o_data = q[i];
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the cascaded FIFO host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fifo_host_pkg::*;
	logic clk;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic irq;
	logic [N_DEV-1:0] wr_n, rd_n, fsel_n, tin_n, ef_n, ff_n, tout_n;
	logic clr_n, rt_n, oe, hf_n;
	logic [DATA_W-1:0] dout, din;
	logic [31:0] q;
	int err_total = 0;
	int comparisons = 0;
	fifo_host fifo_host_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
		.I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.O_IRQ(irq), .O_WRITE_N(wr_n), .O_READ_N(rd_n),
		.O_MASTER_CLEAR_N(clr_n), .O_REPLAY_PULSE_N(rt_n),
		.O_FIRST_DEVICE_SELECT_N(fsel_n), .O_CHAIN_TOKEN_IN_N(tin_n),
		.O_DATA(dout), .O_DATA_OE(oe), .I_DATA(din),
		.I_EMPTY_FLAG_N(ef_n), .I_FULL_FLAG_N(ff_n),
		.I_HALF_LEVEL_FLAG_N(hf_n), .I_CHAIN_TOKEN_OUT_N(tout_n));
	fifo_dev_model fifo_dev_model_inst (.i_write_n(wr_n), .i_read_n(rd_n),
		.i_clear_n(clr_n), .i_replay_n(rt_n), .i_token_in_n(tin_n),
		.i_data(dout), .o_data(din), .o_empty_n(ef_n), .o_full_n(ff_n),
		.o_half_n(hf_n), .o_token_out_n(tout_n));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic end_sim;
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Classic single cycle; request held until the edge that samples ack
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t no bus acknowledge", $time);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	// Issue a command, then poll until the sequencer is idle
	task automatic cmd(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d);
		for (int i = 0; i < 40; i++) begin
			wb(ADR_STAT, 1'b0, 32'h0);
			if (q[0] === 1'b0) break;
		end
		if (q[0] !== 1'b0) begin
			err_total++;
			$display("[ERR] %0t sequencer stuck busy", $time);
		end
	endtask
	task automatic rd_fifo(input logic [31:0] e);
		cmd(ADR_RDATA, 32'h0);
		wb(ADR_RDATA, 1'b0, 32'h0);
		chk(q, e);
	endtask
	// Strobe relations watched throughout
	always @(negedge clk) begin
		if (rst_n && fsel_n[0] && wr_n[0] !== wr_n[1]) begin
			err_total++;
			$display("[ERR] %0t width strobes differ", $time);
		end
		if (rst_n && $countones(~wr_n) > 1 && !fsel_n[0]) begin
			err_total++;
			$display("[ERR] %0t two writers active", $time);
		end
		if (rst_n && oe !== ~&wr_n) begin
			err_total++;
			$display("[ERR] %0t data drive outside write", $time);
		end
	end
	task automatic t_reset;
		chk({24'h0, fsel_n, tin_n}, 32'h0C);
		wb(ADR_CTRL, 1'b0, 32'h0);
		chk(q, 32'h0);
		wb(8'h20, 1'b0, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_width;
		cmd(ADR_CTRL, 32'h2);
		cmd(ADR_WDATA, 32'h1A5);
		cmd(ADR_WDATA, 32'h0F0);
		wb(ADR_IRQ, 1'b0, 32'h0);
		chk(q & 32'h7, 32'h1);
		wb(ADR_MASK, 1'b1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(ADR_IRQ, 1'b1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd_fifo(32'h1A5);
		rd_fifo(32'h0F0);
		cmd(ADR_RDATA, 32'h0);
		wb(ADR_IRQ, 1'b0, 32'h0);
		chk(q & 32'h4, 32'h4);
		wb(ADR_IRQ, 1'b1, 32'h7);
		$display("width test done");
	endtask
	task automatic t_full;
		cmd(ADR_CTRL, 32'h2);
		for (int i = 0; i < 4; i++) cmd(ADR_WDATA, 32'h30 + i);
		wb(ADR_STAT, 1'b0, 32'h0);
		chk(q & 32'h6, 32'h4);
		cmd(ADR_WDATA, 32'h1FF);
		wb(ADR_IRQ, 1'b0, 32'h0);
		chk(q & 32'h4, 32'h4);
		rd_fifo(32'h30);
		cmd(ADR_CTRL, 32'h4);
		rd_fifo(32'h30);
		rd_fifo(32'h31);
		$display("full and replay test done");
	endtask
	task automatic t_depth;
		cmd(ADR_CTRL, 32'h3);
		wb(ADR_IRQ, 1'b1, 32'h7);
		chk({30'h0, fsel_n}, 32'h2);
		chk({30'h0, tin_n}, {30'h0, tout_n[0], tout_n[1]});
		for (int i = 0; i < 5; i++) cmd(ADR_WDATA, 32'h100 + i);
		chk({30'h0, ef_n}, 32'h3);
		for (int i = 0; i < 5; i++) rd_fifo(32'h100 + i);
		cmd(ADR_CTRL, 32'h5);
		wb(ADR_IRQ, 1'b0, 32'h0);
		chk(q & 32'h4, 32'h4);
		$display("depth test done");
	endtask
	initial begin
		#2000000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_width();
		t_full();
		t_depth();
		end_sim();
	end
endmodule
`default_nettype wire

// ---- hw/fifo_host.sv ----
// Host controller for a bank of cascaded asynchronous FIFOs
`timescale 1ns/1ps
`default_nettype none
module fifo_host
	import fifo_host_pkg::*;
(
	// Clock and reset
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RST_N,
	// Wishbone slave
	input  wire logic              I_WB_CYC,
	input  wire logic              I_WB_STB,
	input  wire logic              I_WB_WE,
	input  wire logic [7:0]        I_WB_ADR,
	input  wire logic [3:0]        I_WB_SEL,
	input  wire logic [31:0]       I_WB_DAT,
	output logic      [31:0]       O_WB_DAT,
	output logic                   O_WB_ACK,
	output logic                   O_IRQ,
	// Common FIFO strobes, one group of devices per depth slot
	output logic      [N_DEV-1:0]  O_WRITE_N,
	output logic      [N_DEV-1:0]  O_READ_N,
	output logic                   O_MASTER_CLEAR_N,
	output logic                   O_REPLAY_PULSE_N,
	output logic      [N_DEV-1:0]  O_FIRST_DEVICE_SELECT_N,
	output logic      [N_DEV-1:0]  O_CHAIN_TOKEN_IN_N,
	// Data bus, shared three-state
	output logic      [DATA_W-1:0] O_DATA,
	output logic                   O_DATA_OE,
	input  wire logic [DATA_W-1:0] I_DATA,
	// Device flags and tokens
	input  wire logic [N_DEV-1:0]  I_EMPTY_FLAG_N,
	input  wire logic [N_DEV-1:0]  I_FULL_FLAG_N,
	input  wire logic              I_HALF_LEVEL_FLAG_N,
	input  wire logic [N_DEV-1:0]  I_CHAIN_TOKEN_OUT_N
);
	state_t           s_reg;
	state_t           s_next;
	wb_req_t          req;
	logic [N_DEV-1:0] ef1_reg, ef2_reg;
	logic [N_DEV-1:0] ff1_reg, ff2_reg;
	logic [N_DEV-1:0] xo1_reg, xo2_reg, xo3_reg;
	logic             hf1_reg, hf2_reg;
	logic [DATA_W-1:0] q1_reg, q2_reg;
	logic             any_empty;
	logic             any_full;
	logic [N_DEV-1:0] xo_fall;
	logic             acc;
	logic [IRQ_W-1:0] ev;

	assign req = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE,
		adr: I_WB_ADR, dat: I_WB_DAT};

	// Two-stage synchronisers; tokens add a third stage, read with the second for edges
	always_ff @(posedge I_CORE_CLK) begin
		ef1_reg <= I_EMPTY_FLAG_N;
		ef2_reg <= ef1_reg;
		ff1_reg <= I_FULL_FLAG_N;
		ff2_reg <= ff1_reg;
		xo1_reg <= I_CHAIN_TOKEN_OUT_N;
		xo2_reg <= xo1_reg;
		xo3_reg <= xo2_reg;
		hf1_reg <= I_HALF_LEVEL_FLAG_N;
		hf2_reg <= hf1_reg;
		q1_reg  <= I_DATA;
		q2_reg  <= q1_reg;
	end

	// Composite flags: width trusts any device, depth ORs the low flags
	always_comb begin
		if (s_reg.depth) begin
			any_empty = ~|ef2_reg;
			any_full  = ~|ff2_reg;
		end else begin
			any_empty = ~&ef2_reg;
			any_full  = ~&ff2_reg;
		end
	end

	// Token falling edges mark an ownership hand-over
	assign xo_fall = xo3_reg & ~xo2_reg;
	assign acc     = req.cyc & req.stb & ~s_reg.ack;

	// Next-state logic for bus, sequencer and strobes
	always_comb begin
		s_next     = s_reg;
		s_next.ack = 1'b0;
		ev         = '0;
		if (s_reg.phase == ST_IDLE)
			s_next.busy = 1'b0;
		unique case (s_reg.phase)
		ST_IDLE: begin
		end
		ST_CLEAR: begin
			if (s_reg.cnt == CNT_RST) begin
				s_next.clr_n = 1'b1;
				s_next.phase = ST_RECOV;
				s_next.cnt   = RECOV_CNT;
				s_next.wr_own = {{(N_DEV-1){1'b0}}, 1'b1};
				s_next.rd_own = {{(N_DEV-1){1'b0}}, 1'b1};
			end else
				s_next.cnt = s_reg.cnt - 4'h1;
		end
		ST_WRITE: begin
			if (s_reg.cnt == CNT_RST) begin
				s_next.wr_n    = 1'b1;
				s_next.drive_d = 1'b0;
				s_next.phase   = ST_RECOV;
				s_next.cnt     = RECOV_CNT;
				ev[IRQ_WDONE]  = 1'b1;
			end else
				s_next.cnt = s_reg.cnt - 4'h1;
		end
		ST_READ: begin
			if (s_reg.cnt == CNT_RST) begin
				s_next.rdata  = q2_reg;
				s_next.rd_n   = 1'b1;
				s_next.phase  = ST_RECOV;
				s_next.cnt    = RECOV_CNT;
				ev[IRQ_RDONE] = 1'b1;
			end else
				s_next.cnt = s_reg.cnt - 4'h1;
		end
		ST_REPLAY: begin
			if (s_reg.cnt == CNT_RST) begin
				s_next.rt_n  = 1'b1;
				s_next.phase = ST_RECOV;
				s_next.cnt   = RECOV_CNT;
			end else
				s_next.cnt = s_reg.cnt - 4'h1;
		end
		ST_RECOV: begin
			// Recovery with strobes high keeps pulse width honest
			if (s_reg.cnt == CNT_RST)
				s_next.phase = ST_IDLE;
			else
				s_next.cnt = s_reg.cnt - 4'h1;
		end
		endcase

		// Token seen: pass ownership to the next device in the ring
		// Write and read tokens look alike; the last strobe tells them apart
		if (s_reg.depth) begin
			if (|(xo_fall & s_reg.wr_own) && s_reg.wr_n && s_reg.last_wr)
				s_next.wr_own = {s_reg.wr_own[N_DEV-2:0],
					s_reg.wr_own[N_DEV-1]};
			if (|(xo_fall & s_reg.rd_own) && s_reg.rd_n && !s_reg.last_wr)
				s_next.rd_own = {s_reg.rd_own[N_DEV-2:0],
					s_reg.rd_own[N_DEV-1]};
		end

		// Register access; commands start only from idle
		if (acc) begin
			s_next.ack = 1'b1;
			if (req.we) begin
				unique case (req.adr)
				ADR_CTRL: if (I_WB_SEL[0] && s_reg.phase == ST_IDLE) begin
					if (req.dat[CTRL_CLEAR]) begin
						s_next.depth  = req.dat[CTRL_DEPTH];
						s_next.clr_n  = 1'b0;
						s_next.busy   = 1'b1;
						s_next.phase  = ST_CLEAR;
						s_next.cnt    = PULSE_CNT;
					end else if (req.dat[CTRL_RPLAY]) begin
						if (s_reg.depth)
							ev[IRQ_REFUSE] = 1'b1;
						else begin
							s_next.rt_n  = 1'b0;
							s_next.busy  = 1'b1;
							s_next.phase = ST_REPLAY;
							s_next.cnt   = PULSE_CNT;
						end
					end
				end
				ADR_WDATA: if (s_reg.phase == ST_IDLE) begin
					if (any_full)
						ev[IRQ_REFUSE] = 1'b1;
					else begin
						s_next.wdata   = req.dat[DATA_W-1:0];
						s_next.drive_d = 1'b1;
						s_next.last_wr = 1'b1;
						s_next.wr_n    = 1'b0;
						s_next.busy    = 1'b1;
						s_next.phase   = ST_WRITE;
						s_next.cnt     = PULSE_CNT;
					end
				end
				ADR_RDATA: if (s_reg.phase == ST_IDLE) begin
					if (any_empty)
						ev[IRQ_REFUSE] = 1'b1;
					else begin
						s_next.rd_n  = 1'b0;
						s_next.last_wr = 1'b0;
						s_next.busy  = 1'b1;
						s_next.phase = ST_READ;
						s_next.cnt   = PULSE_CNT;
					end
				end
				ADR_IRQ:  s_next.irq  = s_reg.irq &
					~req.dat[IRQ_W-1:0];
				ADR_MASK: s_next.mask = req.dat[IRQ_W-1:0];
				default: ;
				endcase
			end else begin
				unique case (req.adr)
				ADR_CTRL:  s_next.dat_o = {31'h0, s_reg.depth};
				ADR_STAT:  s_next.dat_o = {27'h0, ~hf2_reg & ~s_reg.depth,
					s_reg.busy, any_full, any_empty, s_reg.phase != ST_IDLE};
				ADR_RDATA: s_next.dat_o = {{(32-DATA_W){1'b0}}, s_reg.rdata};
				ADR_IRQ:   s_next.dat_o = {{(32-IRQ_W){1'b0}}, s_reg.irq};
				ADR_MASK:  s_next.dat_o = {{(32-IRQ_W){1'b0}}, s_reg.mask};
				default:   s_next.dat_o = 32'h0;
				endcase
			end
		end
		// Set wins over a write-one clear in the same cycle
		s_next.irq = s_next.irq | ev;
	end

	// State register with synchronous reset
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			s_reg         <= '0;
			s_reg.phase   <= ST_IDLE;
			s_reg.wr_n    <= 1'b1;
			s_reg.rd_n    <= 1'b1;
			s_reg.clr_n   <= 1'b1;
			s_reg.rt_n    <= 1'b1;
			s_reg.wr_own  <= {{(N_DEV-1){1'b0}}, 1'b1};
			s_reg.rd_own  <= {{(N_DEV-1){1'b0}}, 1'b1};
		end else
			s_reg <= s_next;
	end

	// Strobes go only to the owning device in depth mode
	always_comb begin
		if (s_reg.depth) begin
			O_WRITE_N = ~(s_reg.wr_own & {N_DEV{~s_reg.wr_n}});
			O_READ_N  = ~(s_reg.rd_own & {N_DEV{~s_reg.rd_n}});
		end else begin
			O_WRITE_N = {N_DEV{s_reg.wr_n}};
			O_READ_N  = {N_DEV{s_reg.rd_n}};
		end
	end

	// Strap pins: token ring and one first select low in depth mode; tokens grounded, selects high in width mode
	always_comb begin
		if (s_reg.depth) begin
			O_FIRST_DEVICE_SELECT_N    = ~{{(N_DEV-1){1'b0}}, 1'b1};
			O_CHAIN_TOKEN_IN_N         = {I_CHAIN_TOKEN_OUT_N[N_DEV-2:0],
				I_CHAIN_TOKEN_OUT_N[N_DEV-1]};
		end else begin
			O_FIRST_DEVICE_SELECT_N    = '1;
			O_CHAIN_TOKEN_IN_N         = '0;
		end
	end

	assign O_MASTER_CLEAR_N = s_reg.clr_n;
	assign O_REPLAY_PULSE_N = s_reg.rt_n;
	assign O_DATA           = s_reg.wdata;
	assign O_DATA_OE        = s_reg.drive_d;
	assign O_WB_ACK         = s_reg.ack;
	assign O_WB_DAT         = s_reg.dat_o;
	assign O_IRQ            = |(s_reg.irq & s_reg.mask);

	// Write strobe stays low for the pulse count plus one cycle
	sequence s_wr_start;
		$fell(s_reg.wr_n);
	endsequence
	a_write_pulse_len: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_wr_start |-> !s_reg.wr_n [*3] ##1 s_reg.wr_n)
		else $error("write pulse length wrong");
	a_no_write_full: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(acc && req.we && req.adr == ADR_WDATA && any_full)
		|=> s_reg.wr_n)
		else $error("write issued to full fifo");
	a_no_read_empty: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(acc && req.we && req.adr == ADR_RDATA && any_empty)
		|=> s_reg.rd_n)
		else $error("read issued to empty fifo");
	a_one_writer: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_reg.depth |-> $onehot(s_reg.wr_own))
		else $error("write owner not unique");
	a_one_reader: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_reg.depth |-> $onehot(s_reg.rd_own))
		else $error("read owner not unique");
	a_width_straps: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		!s_reg.depth |-> (&O_FIRST_DEVICE_SELECT_N
		&& ~|O_CHAIN_TOKEN_IN_N))
		else $error("width straps wrong");
	a_no_replay_depth: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(acc && req.we && req.adr == ADR_CTRL && req.dat[CTRL_RPLAY] &&
		s_reg.depth) |=> s_reg.rt_n)
		else $error("replay in depth mode");
	a_token_hand: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(s_reg.depth && s_reg.wr_n && s_reg.last_wr &&
		|(xo_fall & s_reg.wr_own))
		|=> s_reg.wr_own != $past(s_reg.wr_own))
		else $error("token did not move ownership");
	a_ack_one_cycle: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		O_WB_ACK |=> !O_WB_ACK)
		else $error("ack held too long");

	// Read and clear strobes share the write pulse shape
	sequence s_rd_start;
		$fell(s_reg.rd_n);
	endsequence
	sequence s_clr_start;
		$fell(s_reg.clr_n);
	endsequence
	a_read_pulse_len: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_rd_start |-> !s_reg.rd_n [*3] ##1 s_reg.rd_n)
		else $error("read pulse length wrong");
	a_clear_pulse_len: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_clr_start |-> !s_reg.clr_n [*3] ##1 s_reg.clr_n)
		else $error("clear pulse length wrong");
	// Overlapping strobes would invite effective pulse width violations
	a_strobe_excl: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		!(!s_reg.wr_n && !s_reg.rd_n))
		else $error("read and write strobes overlap");
	a_drive_with_write: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		O_DATA_OE == !s_reg.wr_n)
		else $error("data bus driven outside write");
	a_ack_latency: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		acc |=> O_WB_ACK)
		else $error("request not acknowledged");
	a_depth_straps: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_reg.depth |-> (!O_FIRST_DEVICE_SELECT_N[0] &&
		$countones(O_FIRST_DEVICE_SELECT_N) == N_DEV - 1))
		else $error("depth straps wrong");
	a_refuse_full: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(acc && req.we && req.adr == ADR_WDATA && any_full &&
		s_reg.phase == ST_IDLE) |=> s_reg.irq[IRQ_REFUSE])
		else $error("refused write not flagged");
endmodule
`default_nettype wire

// ---- hw/fifo_host_pkg.sv ----
// Constants and types for the cascaded FIFO host controller
// Overview of operation
// - Standalone/width mode: token input low, first select high on every device.
// - Word width grows by nine bits per device placed side by side.
// - Host drives all control inputs in common to every device.
// - Depth mode: tokens form a ring through all devices during clear.
// - Exactly one device has first select low; all others high.
// - Host forms composite full by ORing active-low full flags.
// - Host forms composite empty by ORing active-low empty flags.
// - Host withholds reads when empty and writes when full.
package fifo_host_pkg;
	localparam int          N_DEV      = 2;
	localparam int          WORD_W     = 9;
	localparam int          DATA_W     = N_DEV * WORD_W;
	// Wishbone register map (byte addresses)
	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_STAT   = 8'h04;
	localparam logic [7:0]  ADR_WDATA  = 8'h08;
	localparam logic [7:0]  ADR_RDATA  = 8'h0C;
	localparam logic [7:0]  ADR_IRQ    = 8'h10;
	localparam logic [7:0]  ADR_MASK   = 8'h14;
	// Control field positions
	localparam int          CTRL_DEPTH = 0;
	localparam int          CTRL_CLEAR = 1;
	localparam int          CTRL_RPLAY = 2;
	// Interrupt bit positions
	localparam int          IRQ_WDONE  = 0;
	localparam int          IRQ_RDONE  = 1;
	localparam int          IRQ_REFUSE = 2;
	localparam int          IRQ_W      = 3;
	// Strobe timing: low phase and recovery, in ns and cycles
	localparam int          CLK_NS     = 50;
	localparam int          PULSE_NS   = 65;
	localparam int          RECOV_NS   = 15;
	localparam int          PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RECOV_CYC  = (RECOV_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0]  PULSE_CNT  = 4'(PULSE_CYC);
	localparam logic [3:0]  RECOV_CNT  = 4'(RECOV_CYC);
	localparam logic [3:0]  CNT_RST    = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE, ST_CLEAR, ST_WRITE, ST_READ, ST_REPLAY, ST_RECOV
	} phase_t;
	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [7:0]        adr;
		logic [31:0]       dat;
	} wb_req_t;
	typedef struct packed {
		phase_t            phase;
		logic [3:0]        cnt;
		logic              depth;
		logic [N_DEV-1:0]  wr_own;
		logic [N_DEV-1:0]  rd_own;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              busy;
		logic [IRQ_W-1:0]  irq;
		logic [IRQ_W-1:0]  mask;
		logic              ack;
		logic [31:0]       dat_o;
		logic              wr_n;
		logic              rd_n;
		logic              clr_n;
		logic              rt_n;
		logic              drive_d;
		logic              last_wr;
	} state_t;
endpackage
